// file: logic/mas_pkg.sv
// How it works
// - Step 1: program counter via adder into address
// - Step 2: memory read into buffer register
// - Step 3: buffer register via adder into instruction
// - Step 4: dispatch on instruction opcode field
// - Add step 1: address field into address register
// - Add step 2: read operand into buffer register
// - Add step 3: accumulator plus buffer into accumulator
// - Increment program counter by one through adder
// - Last step jumps back to fetch start
// - Control word parity check sets a fault flag that holds until reset
// - Control address advances unless jump encoded
// - Plus code sums memory bus and data bus
// - One code passes data bus plus one
// - Dispatch jump loads address from opcode field
package mas_pkg;
  localparam int unsigned MAS_DW = 16;
  localparam int unsigned MAS_OPW = 4;
  localparam int unsigned MAS_AW = MAS_DW - MAS_OPW;
  localparam int unsigned MAS_CSW = 5;
  localparam logic [MAS_CSW-1:0] MAS_FETCH_START = 5'h00;
  // Control steps that read main memory
  localparam logic [MAS_CSW-1:0] MAS_CS_INSTR_READ = 5'h01;
  localparam logic [MAS_CSW-1:0] MAS_CS_OPND_READ = 5'h12;
  localparam logic [MAS_AW-1:0] MAS_PC_RESET = 12'h000;
  localparam logic [MAS_DW-1:0] MAS_ACC_RESET = 16'h0000;

  typedef enum logic [1:0] {MAS_MEM_NONE, MAS_MEM_READ, MAS_MEM_WRITE} mas_mem_t;
  typedef enum logic [1:0] {MAS_JMP_NONE, MAS_JMP_ZERO, MAS_JMP_NZ, MAS_JMP_OPC} mas_jmp_t;
  typedef enum logic [2:0] {MAS_ADD_NONE, MAS_ADD_PLUS, MAS_ADD_MTS, MAS_ADD_ONE,
                            MAS_ADD_DTS} mas_add_t;
  typedef enum logic [1:0] {MAS_MB_NONE, MAS_MB_ADDR, MAS_MB_BUF} mas_mb_t;
  typedef enum logic [1:0] {MAS_DB_NONE, MAS_DB_PC, MAS_DB_IA, MAS_DB_ACC} mas_db_t;
  typedef enum logic [2:0] {MAS_SB_NONE, MAS_SB_ADDR, MAS_SB_BUF, MAS_SB_PC, MAS_SB_IR,
                            MAS_SB_ACC} mas_sb_t;

  typedef struct packed {
    mas_mem_t mem;
    mas_jmp_t control_jump;
    mas_add_t add;
    mas_mb_t mb;
    mas_db_t db;
    mas_sb_t sb;
    logic [MAS_CSW-1:0] jaddr;
  } mas_uinstr_t;

  localparam int unsigned MAS_UIW = $bits(mas_uinstr_t);

  // Memory request toward main memory
  typedef struct packed {
    logic rd;
    logic wr;
    logic [MAS_AW-1:0] addr;
    logic [MAS_DW-1:0] wdata;
  } mas_mem_req_t;
endpackage

// file: logic/mas_control_store.sv
`timescale 1ns/1ps
// Control store: add-to-accumulator microprogram, with one even-parity bit per word
module mas_control_store
  import mas_pkg::*;
(
  // Address in
  input wire logic [mas_pkg::MAS_CSW-1:0] i_addr,
  // Word out
  output logic [mas_pkg::MAS_UIW-1:0] o_word,
  output logic o_parity
);
  mas_uinstr_t w;

  always_comb
  begin
    w = '{MAS_MEM_NONE, MAS_JMP_NONE, MAS_ADD_NONE, MAS_MB_NONE, MAS_DB_NONE, MAS_SB_NONE,
          MAS_FETCH_START};
    case (i_addr)
      5'h00: w = '{MAS_MEM_NONE, MAS_JMP_NONE, MAS_ADD_DTS, MAS_MB_NONE, MAS_DB_PC,
                   MAS_SB_ADDR, MAS_FETCH_START};
      5'h01: w = '{MAS_MEM_READ, MAS_JMP_NONE, MAS_ADD_NONE, MAS_MB_NONE, MAS_DB_NONE,
                   MAS_SB_NONE, MAS_FETCH_START};
      5'h02: w = '{MAS_MEM_NONE, MAS_JMP_NONE, MAS_ADD_MTS, MAS_MB_BUF, MAS_DB_NONE,
                   MAS_SB_IR, MAS_FETCH_START};
      5'h03: w = '{MAS_MEM_NONE, MAS_JMP_OPC, MAS_ADD_NONE, MAS_MB_NONE, MAS_DB_NONE,
                   MAS_SB_NONE, MAS_FETCH_START};
      // Add routine sits at opcode 1 dispatch target
      5'h11: w = '{MAS_MEM_NONE, MAS_JMP_NONE, MAS_ADD_DTS, MAS_MB_NONE, MAS_DB_IA,
                   MAS_SB_ADDR, MAS_FETCH_START};
      5'h12: w = '{MAS_MEM_READ, MAS_JMP_NONE, MAS_ADD_NONE, MAS_MB_NONE, MAS_DB_NONE,
                   MAS_SB_NONE, MAS_FETCH_START};
      5'h13: w = '{MAS_MEM_NONE, MAS_JMP_NONE, MAS_ADD_PLUS, MAS_MB_BUF, MAS_DB_ACC,
                   MAS_SB_ACC, MAS_FETCH_START};
      5'h14: w = '{MAS_MEM_NONE, MAS_JMP_NONE, MAS_ADD_ONE, MAS_MB_NONE, MAS_DB_PC,
                   MAS_SB_PC, MAS_FETCH_START};
      5'h15: w = '{MAS_MEM_NONE, MAS_JMP_ZERO, MAS_ADD_NONE, MAS_MB_NONE, MAS_DB_NONE,
                   MAS_SB_NONE, MAS_FETCH_START};
      // Unused slots return to fetch so a bad opcode cannot run away
      default: w.control_jump = MAS_JMP_ZERO;
    endcase
  end

  assign o_word = w;
  assign o_parity = ^w;
endmodule

// file: logic/mas_sequencer.sv
`timescale 1ns/1ps
module mas_sequencer
  import mas_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Main memory read data, valid in the same cycle as the read request
  input wire logic [mas_pkg::MAS_DW-1:0] i_mem_rdata,
  // Main memory request
  output mas_pkg::mas_mem_req_t o_mem_req,
  // Observation
  output logic [mas_pkg::MAS_DW-1:0] o_accumulator,
  output logic [mas_pkg::MAS_AW-1:0] o_program_counter,
  output logic [mas_pkg::MAS_CSW-1:0] o_cs_addr,
  output logic o_parity_fault
);
  import mas_pkg::*;

  typedef struct packed {
    logic [MAS_CSW-1:0] cs_addr;
    logic [MAS_AW-1:0] mem_addr_reg;
    logic [MAS_DW-1:0] mem_buf_reg;
    logic [MAS_DW-1:0] instr_reg;
    logic [MAS_DW-1:0] accumulator;
    logic [MAS_AW-1:0] program_counter;
    logic parity_fault;
    mas_mem_req_t req;
  } mas_state_t;

  mas_state_t r;
  mas_state_t next_r;
  logic [MAS_UIW-1:0] cs_word;
  logic cs_parity;
  mas_uinstr_t ui;
  logic [MAS_DW-1:0] mbus;
  logic [MAS_DW-1:0] dbus;
  logic [MAS_DW-1:0] sbus;
  logic [MAS_AW-1:0] instr_address_field;

  mas_control_store u_cs (
    .i_addr(r.cs_addr),
    .o_word(cs_word),
    .o_parity(cs_parity)
  );

  assign ui = mas_uinstr_t'(cs_word);
  assign instr_address_field = r.instr_reg[MAS_AW-1:0];

  always_comb
  begin
    mbus = '0;
    case (ui.mb)
      MAS_MB_ADDR: mbus = {{MAS_OPW{1'b0}}, r.mem_addr_reg};
      MAS_MB_BUF: mbus = r.mem_buf_reg;
      default: mbus = '0;
    endcase
    dbus = '0;
    case (ui.db)
      MAS_DB_PC: dbus = {{MAS_OPW{1'b0}}, r.program_counter};
      MAS_DB_IA: dbus = {{MAS_OPW{1'b0}}, instr_address_field};
      MAS_DB_ACC: dbus = r.accumulator;
      default: dbus = '0;
    endcase
    sbus = '0;
    case (ui.add)
      MAS_ADD_PLUS: sbus = mbus + dbus;
      MAS_ADD_MTS: sbus = mbus;
      MAS_ADD_ONE: sbus = dbus + 16'h0001;
      MAS_ADD_DTS: sbus = dbus;
      default: sbus = '0;
    endcase
  end

  always_comb
  begin
    next_r = r;
    next_r.req.rd = 1'b0;
    next_r.req.wr = 1'b0;
    // Read completes in the cycle of its step
    if (ui.mem == MAS_MEM_READ)
    begin
      next_r.mem_buf_reg = i_mem_rdata;
    end
    case (ui.sb)
      MAS_SB_ADDR: next_r.mem_addr_reg = sbus[MAS_AW-1:0];
      MAS_SB_BUF: next_r.mem_buf_reg = sbus;
      MAS_SB_PC: next_r.program_counter = sbus[MAS_AW-1:0];
      MAS_SB_IR: next_r.instr_reg = sbus;
      MAS_SB_ACC: next_r.accumulator = sbus;
      default: next_r.accumulator = r.accumulator;
    endcase
    // Request for the coming step, registered so it lines up with that step
    next_r.req.addr = next_r.mem_addr_reg;
    next_r.req.wdata = next_r.mem_buf_reg;
    case (ui.control_jump)
      MAS_JMP_ZERO: next_r.cs_addr = ui.jaddr;
      MAS_JMP_NZ:
      begin
        if (r.accumulator != MAS_ACC_RESET)
          next_r.cs_addr = ui.jaddr;
        else
          next_r.cs_addr = r.cs_addr + 5'h01;
      end
      MAS_JMP_OPC: next_r.cs_addr = {1'b1, r.instr_reg[MAS_DW-1 -: MAS_OPW]};
      default: next_r.cs_addr = r.cs_addr + 5'h01;
    endcase
    if (cs_parity != ^cs_word)
      next_r.parity_fault = 1'b1;
    // Read strobe is registered, so it stands during the read step itself
    if (next_r.cs_addr == MAS_CS_INSTR_READ || next_r.cs_addr == MAS_CS_OPND_READ)
      next_r.req.rd = 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      r <= '0;
      r.cs_addr <= MAS_FETCH_START;
      r.program_counter <= MAS_PC_RESET;
      r.accumulator <= MAS_ACC_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_mem_req = r.req;
  assign o_accumulator = r.accumulator;
  assign o_program_counter = r.program_counter;
  assign o_cs_addr = r.cs_addr;
  assign o_parity_fault = r.parity_fault;

  a_fetch_addr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    r.cs_addr == 5'h00 |=> r.mem_addr_reg == $past(r.program_counter))
    else $error("fetch address not taken from program counter");
  a_fetch_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    r.cs_addr == 5'h01 |-> r.req.rd ##1 r.mem_buf_reg == $past(i_mem_rdata))
    else $error("instruction read missing");
  a_ir_load: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    r.cs_addr == 5'h02 |=> r.instr_reg == $past(r.mem_buf_reg))
    else $error("instruction register not loaded");
  a_dispatch: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    r.cs_addr == 5'h03 |=> r.cs_addr == {1'b1, $past(r.instr_reg[15:12])})
    else $error("opcode dispatch wrong");
  a_operand_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    r.cs_addr == 5'h12 |-> r.req.rd ##1 r.mem_buf_reg == $past(i_mem_rdata))
    else $error("operand read missing");
  a_operand_addr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    r.cs_addr == 5'h11 |=> r.mem_addr_reg == $past(instr_address_field))
    else $error("operand address wrong");
  a_acc_sum: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    r.cs_addr == 5'h12 |=> ##1 r.accumulator == $past(r.accumulator) + $past(r.mem_buf_reg))
    else $error("accumulator sum wrong");
  a_pc_step: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    r.cs_addr == 5'h14 |=> r.program_counter == $past(r.program_counter) + 12'h001)
    else $error("program counter not incremented");
  a_return: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    r.cs_addr == 5'h15 |=> r.cs_addr == MAS_FETCH_START)
    else $error("no return to fetch");
  a_seq_step: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ui.control_jump == MAS_JMP_NONE |=> r.cs_addr == $past(r.cs_addr) + 5'h01)
    else $error("sequential advance broken");
  a_no_fault: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !r.parity_fault)
    else $error("control store parity fault");
endmodule

// file: verif/mas_mem_model.sv
`timescale 1ns/1ps
module mas_mem_model
  import mas_pkg::*;
(
  // Clock
  input wire logic i_clk_sys,
  // Request from the sequencer
  input wire mas_pkg::mas_mem_req_t i_mem_req,
  // Read data back
  output logic [mas_pkg::MAS_DW-1:0] o_rdata
);
  logic [MAS_DW-1:0] mem [1 << MAS_AW];
  logic [MAS_DW-1:0] last;

  // Asynchronous array, so the word settles inside the request cycle
  always_comb
  begin
    if (i_mem_req.rd)
      o_rdata = mem[i_mem_req.addr];
    else
      o_rdata = ~last;
  end

  // Idle bus shows the inverse of the last word, never a stale copy
  always_ff @(posedge i_clk_sys)
  begin
    if (i_mem_req.rd)
      last <= o_rdata;
  end

  task automatic load(input logic [MAS_AW-1:0] a, input logic [MAS_DW-1:0] d);
    mem[a] = d;
  endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import mas_pkg::*;
  logic i_clk_sys;
  logic i_nrst;
  logic [MAS_DW-1:0] mem_rdata;
  mas_mem_req_t mem_req;
  logic [MAS_DW-1:0] acc;
  logic [MAS_AW-1:0] pc;
  logic [MAS_CSW-1:0] cs;
  logic pfault;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [MAS_DW-1:0] exp_acc = 16'h0000;

  mas_sequencer dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_mem_rdata(mem_rdata),
    .o_mem_req(mem_req), .o_accumulator(acc), .o_program_counter(pc), .o_cs_addr(cs),
    .o_parity_fault(pfault));
  mas_mem_model mem_u (.i_clk_sys(i_clk_sys), .i_mem_req(mem_req), .o_rdata(mem_rdata));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [MAS_DW-1:0] got, input logic [MAS_DW-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic step;
    @(posedge i_clk_sys);
    #1;
  endtask

  task automatic wait_fetch;
    for (int i = 0; i < 20 && cs !== MAS_FETCH_START; i++)
      step;
    if (cs !== MAS_FETCH_START)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, cs, MAS_FETCH_START);
      n_mismatch++;
      end_sim;
    end
  endtask

  // Also used in mid-run, where state must drop back to fetch
  task automatic t_reset;
    i_nrst = 1'b0;
    step;
    step;
    chk(16'(cs), 16'h0000);
    chk(acc, 16'h0000);
    chk(16'(pc), 16'h0000);
    chk(16'(mem_req.rd), 16'h0000);
    exp_acc = 16'h0000;
    i_nrst = 1'b1;
  endtask

  task automatic t_add(input logic [MAS_AW-1:0] ia, input logic [MAS_DW-1:0] data);
    logic [MAS_CSW-1:0] seq [9];
    logic [MAS_AW-1:0] pc0;
    seq = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
    wait_fetch;
    pc0 = pc;
    exp_acc = exp_acc + data;
    for (int i = 0; i < 9; i++)
    begin
      chk(16'(cs), 16'(seq[i]));
      chk(16'(mem_req.rd), 16'(i == 1 || i == 5));
      if (i == 1)
        chk(16'(mem_req.addr), 16'(pc0));
      if (i == 5)
        chk(16'(mem_req.addr), 16'(ia));
      step;
    end
    chk(16'(cs), 16'h0000);
    chk(acc, exp_acc);
    chk(16'(pc), 16'(pc0 + 12'h001));
    chk(16'(pfault), 16'h0000);
  endtask

  // Opcode without a routine: back to fetch, nothing changed
  task automatic t_noop;
    logic [MAS_CSW-1:0] seq [5];
    logic [MAS_AW-1:0] pc0;
    seq = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10};
    wait_fetch;
    pc0 = pc;
    for (int i = 0; i < 5; i++)
    begin
      chk(16'(cs), 16'(seq[i]));
      step;
    end
    chk(16'(cs), 16'h0000);
    chk(16'(pc), 16'(pc0));
    chk(acc, exp_acc);
  endtask

  initial
  begin
    i_nrst = 1'b0;
    mem_u.load(12'h000, 16'h1100);
    mem_u.load(12'h001, 16'h1fff);
    mem_u.load(12'h002, 16'h1101);
    mem_u.load(12'h003, 16'h0000);
    mem_u.load(12'h100, 16'h1234);
    mem_u.load(12'hfff, 16'hffff);
    mem_u.load(12'h101, 16'h0001);
    t_reset;
    t_add(12'h100, 16'h1234);
    t_add(12'hfff, 16'hffff);
    t_add(12'h101, 16'h0001);
    t_noop;
    step;
    step;
    t_reset;
    t_add(12'h100, 16'h1234);
    end_sim;
  end
endmodule
